// ---- hw/eaes_select.v ----
`include "eaes_consts.vh"
`default_nettype none
module eaes_select
(
   input wire core_clk_in,
   input wire reset_n_in,
   input wire [15:0] cpu_address_in,
   input wire [5:0] program_page_index_in,
   input wire [1:0] paging_config_switches_in,
   input wire [1:0] flash_size_sel_in,
   input wire flash_high_map_only_in,
   input wire emulation_port_enable_in,
   input wire expanded_mode_in,
   input wire [7:0] gpio_out_in,
   input wire [7:0] gpio_oe_in,
   output reg [7:0] port_k_out,
   output reg [7:0] port_k_oe_out,
   output reg [5:0] extended_address_hi_out,
   output reg emulation_chip_select_n_out,
   output reg emulation_active_out
);
   // Everything below is combinational up to one register stage,
   // so the pins lag the address and page index by exactly one clock
   // Block of the current access: 0 and 1 below the window, 2 the window, 3 the top
   wire [1:0] blk;
   // Emulation signals show on the pins only with the port enabled in an expanded mode
   wire emu_on;
   // Window access falls inside the on-chip page range
   reg page_internal;
   // Chip select and extended address as decoded, ahead of the output register
   reg next_cs_n;
   reg [5:0] next_xa;
   // Port K pin data and enable as they will stand after the next edge
   reg [7:0] next_port_k;
   reg [7:0] next_port_k_oe;

   // Lowest on-chip page for one paging switch setting
   // Setting 3 puts every page on chip, so its base is page 0
   function [5:0] eaes_page_base;
      input [1:0] sw;
      begin
         case (sw)
            2'h0: eaes_page_base = `EAES_PAGE_BASE_SW0;
            2'h1: eaes_page_base = `EAES_PAGE_BASE_SW1;
            2'h2: eaes_page_base = `EAES_PAGE_BASE_SW2;
            default: eaes_page_base = `EAES_PAGE_BASE_SW3;
         endcase
      end
   endfunction

   // True for an access inside the program page window
   // Only there does the page index matter at all
   function eaes_in_window;
      input [1:0] b;
      begin
         eaes_in_window = (b == `EAES_BLK_WINDOW);
      end
   endfunction

   // Fixed extended address code of an unpaged block
   // The window never reaches this decode; it carries the page index instead
   function [5:0] eaes_fixed_code;
      input [1:0] b;
      begin
         case (b)
            `EAES_BLK_LOW: eaes_fixed_code = `EAES_XA_BLK0;
            `EAES_BLK_MID: eaes_fixed_code = `EAES_XA_BLK1;
            default: eaes_fixed_code = `EAES_XA_BLK3;
         endcase
      end
   endfunction

   // Chip select with no flash allocated
   // The window and the top block both go to the emulator
   function eaes_cs_n_0k;
      input [1:0] b;
      begin
         case (b)
            `EAES_BLK_LOW: eaes_cs_n_0k = 1'b1;
            `EAES_BLK_MID: eaes_cs_n_0k = 1'b1;
            default: eaes_cs_n_0k = 1'b0;
         endcase
      end
   endfunction

   // Chip select with 16K allocated
   // Only the top block goes to the emulator, the window included stays high
   function eaes_cs_n_16k;
      input [1:0] b;
      begin
         case (b)
            `EAES_BLK_LOW: eaes_cs_n_16k = 1'b1;
            `EAES_BLK_MID: eaes_cs_n_16k = 1'b1;
            `EAES_BLK_WINDOW: eaes_cs_n_16k = 1'b1;
            default: eaes_cs_n_16k = 1'b0;
         endcase
      end
   endfunction

   // Chip select with 48K allocated
   // Block 1 obeys the high-map bit and the window follows its page range
   function eaes_cs_n_48k;
      input [1:0] b;
      input high_map;
      input internal;
      begin
         case (b)
            `EAES_BLK_LOW: eaes_cs_n_48k = 1'b1;
            `EAES_BLK_MID: eaes_cs_n_48k = high_map;
            `EAES_BLK_WINDOW: eaes_cs_n_48k = ~internal;
            default: eaes_cs_n_48k = 1'b0;
         endcase
      end
   endfunction

   // Chip select with 64K allocated
   // Both low blocks obey the high-map bit and the window follows its page range
   function eaes_cs_n_64k;
      input [1:0] b;
      input high_map;
      input internal;
      begin
         case (b)
            `EAES_BLK_LOW: eaes_cs_n_64k = high_map;
            `EAES_BLK_MID: eaes_cs_n_64k = high_map;
            `EAES_BLK_WINDOW: eaes_cs_n_64k = ~internal;
            default: eaes_cs_n_64k = 1'b0;
         endcase
      end
   endfunction

   // Block select and emulation qualifier
   assign blk = cpu_address_in[15:14];
   assign emu_on = emulation_port_enable_in & expanded_mode_in;

   // Page range classification from the paging switches
   // Switches are integration straps; a change mid-run only shifts the boundary
   always @*
   begin
      page_internal = (program_page_index_in >= eaes_page_base(paging_config_switches_in));
   end

   // Extended address: page index in the window, fixed codes elsewhere
   // Always decoded, even when the pins are lent to general purpose use
   always @*
   begin
      if (eaes_in_window(blk))
         next_xa = program_page_index_in;
      else
         next_xa = eaes_fixed_code(blk);
   end

   // Chip select tables, one per allocated size
   // The size input is a strap, so changes need no glitch guard
   always @*
   begin
      case (flash_size_sel_in)
         `EAES_SIZE_0K: next_cs_n = eaes_cs_n_0k(blk);
         `EAES_SIZE_16K: next_cs_n = eaes_cs_n_16k(blk);
         `EAES_SIZE_48K: next_cs_n =
            eaes_cs_n_48k(blk, flash_high_map_only_in, page_internal);
         default: next_cs_n =
            eaes_cs_n_64k(blk, flash_high_map_only_in, page_internal);
      endcase
   end

   // Port K pin mux: emulation takes bits 7 and 5:0
   // Bit 6 stays general purpose, as the external select is not built here
   always @*
   begin
      if (emu_on)
      begin
         next_port_k = {next_cs_n, gpio_out_in[6], next_xa};
         next_port_k_oe = {1'b1, gpio_oe_in[6], `EAES_XA_ALL_DRIVEN};
      end
      else
      begin
         next_port_k = gpio_out_in;
         next_port_k_oe = gpio_oe_in;
      end
   end

   // Internal view of the decode
   // Registered so that every output comes straight from a flip-flop
   always @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         extended_address_hi_out <= `EAES_RST_XA;
         emulation_chip_select_n_out <= `EAES_RST_CS_N;
      end
      else
      begin
         extended_address_hi_out <= next_xa;
         emulation_chip_select_n_out <= next_cs_n;
      end
   end

   // Emulation qualifier, aligned with the pins it governs
   // Lets port logic know which pins are lent out this cycle
   always @(posedge core_clk_in)
   begin
      if (!reset_n_in)
         emulation_active_out <= 1'b0;
      else
         emulation_active_out <= emu_on;
   end

   // Registered pins; one cycle of latency buys glitch-free pins
   // Reset releases every pin, so nothing is driven until the first decode
   always @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         port_k_out <= `EAES_RST_PORT;
         port_k_oe_out <= `EAES_RST_PORT;
      end
      else
      begin
         port_k_out <= next_port_k;
         port_k_oe_out <= next_port_k_oe;
      end
   end
endmodule
`default_nettype wire

// ---- shared/eaes_consts.vh ----
// Functional notes
// - With the emulation port enabled in an expanded mode, a window access puts the page index on the extended address lines.
// - Outside the window the extended address is 0x3d, 0x3e or 0x3f for the low, second and top 16K blocks.
// - Extended address and emulation chip select reach the pins only while emulation is enabled in an expanded mode.
// - With 0K allocated, chip select is high below 0x8000 and low from 0x8000 up, whatever the high-map bit.
// - With 16K allocated, chip select is low only for the top block.
// - With 48K allocated, chip select is high for block 0, follows the high-map bit in block 1, low for internal window pages and low in the top block.
// - With 64K allocated, both low blocks are selected unless high-map is set, internal window pages are selected and the top block always is.
// - With emulation enabled, port K bit 7 is the active-low emulation chip select.
// - With emulation disabled, the port K pins are general purpose I/O.
// - A window access is internal when the page index is in the on-chip range set by the paging switches, else external.
`ifndef EAES_CONSTS_VH
`define EAES_CONSTS_VH
`define EAES_XA_BLK0 6'h3d
`define EAES_XA_BLK1 6'h3e
`define EAES_XA_BLK3 6'h3f
`define EAES_BLK_WINDOW 2'h2
`define EAES_BLK_TOP 2'h3
`define EAES_SIZE_0K 2'h0
`define EAES_SIZE_16K 2'h1
`define EAES_SIZE_48K 2'h2
`define EAES_SIZE_64K 2'h3
`define EAES_PAGE_BASE_SW0 6'h38
`define EAES_PAGE_BASE_SW1 6'h30
`define EAES_PAGE_BASE_SW2 6'h20
`define EAES_PAGE_BASE_SW3 6'h00
`define EAES_BLK_LOW 2'h0
`define EAES_BLK_MID 2'h1
`define EAES_XA_ALL_DRIVEN 6'h3f
`define EAES_RST_PORT 8'h00
`define EAES_RST_XA 6'h00
`define EAES_RST_CS_N 1'b1
`define EAES_CS_BIT 7
`endif

// ---- testbench/eaes_emul_model.sv ----
`default_nettype none
module eaes_emul_model
(
   input wire logic [15:0] drive_in,
   output logic [7:0] level_out
);
   timeunit 1ns / 1ns;
   // Upper byte is the enable; a released pin reads high on its pull-up
   assign level_out = drive_in[7:0] | ~drive_in[15:8];
endmodule
`default_nettype wire

// ---- testbench/eaes_select_asserts.sv ----
`default_nettype none
module eaes_select_chk
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [15:0] cpu_address_in,
   input wire logic [5:0] program_page_index_in,
   input wire logic [1:0] flash_size_sel_in,
   input wire logic flash_high_map_only_in,
   input wire logic [5:0] extended_address_hi_out,
   input wire logic emulation_chip_select_n_out
);
   timeunit 1ns / 1ns;
   wire [1:0] b = cpu_address_in[15:14];
   wire [5:0] x = extended_address_hi_out;
   wire c = emulation_chip_select_n_out;
   // Outputs are registered, so every check looks one edge past its cause
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_xa_pg: assert property (b == 2 |=> x == $past(program_page_index_in))
      else $error("xa");
   a_xa_b0: assert property (b == 0 |=> x == 6'h3d) else $error("xa");
   a_xa_b1: assert property (b == 1 |=> x == 6'h3e) else $error("xa");
   a_xa_top: assert property (b == 3 |=> x == 6'h3f) else $error("xa");
   a_cs_top: assert property (b == 3 |=> !c) else $error("cs");
   a_cs_none: assert property (flash_size_sel_in == 0 && b[1] |=> !c) else $error("cs");
   a_cs_small: assert property (flash_size_sel_in == 1 && b != 3 |=> c) else $error("cs");
   a_cs_full: assert property (b == 0 && flash_size_sel_in == 3
      |=> c == $past(flash_high_map_only_in)) else $error("cs");
endmodule
bind eaes_select eaes_select_chk chk (.*);
`default_nettype wire

// ---- testbench/eaes_select_tb.sv ----
`default_nettype none
module eaes_select_tb;
   timeunit 1ns / 1ns;
   logic ck = 0, rn = 0, hm, en, ex, cs, act;
   logic [15:0] a, e = 16'hff40, ek = 16'h0000;
   logic [5:0] p, xa;
   logic [1:0] sw, sz;
   logic [7:0] go, ge, pk, oe, pin;
   logic [6:0] x;
   int failures = 0, check_count = 0, k, b, cyc = 0;
   eaes_select uut (.core_clk_in(ck), .reset_n_in(rn), .cpu_address_in(a),
      .program_page_index_in(p), .paging_config_switches_in(sw), .flash_size_sel_in(sz),
      .flash_high_map_only_in(hm), .emulation_port_enable_in(en), .expanded_mode_in(ex),
      .gpio_out_in(go), .gpio_oe_in(ge), .port_k_out(pk), .port_k_oe_out(oe),
      .extended_address_hi_out(xa), .emulation_chip_select_n_out(cs), .emulation_active_out(act));
   eaes_emul_model far (.drive_in({oe, pk}), .level_out(pin));
   // A run cut short by the cycle ceiling counts as a mismatch
   task report_and_stop;
      failures += int'(cyc >= 1000);
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial forever #50 ck = ~ck;
   always @(posedge ck) if (++cyc == 1000) report_and_stop;
   // Random traffic; each result is compared one cycle after its inputs
   initial
   begin
      {a, p, sw, sz, hm, en, ex, go, ge} = '0;
      void'($urandom(93));
      repeat (4) @(negedge ck);
      for (k = 0; k < 640; k++)
      begin
         @(negedge ck);
         check_count++;
         if ({pin, act, cs, xa} !== e)
         begin
            failures++;
            $display("MISMATCH outputs exp %h got %h", e, {pin, act, cs, xa});
         end
         check_count++;
         if ({pk, oe} !== ek)
         begin
            failures++;
            $display("MISMATCH port_k exp %h got %h", ek, {pk, oe});
         end
         rn = k % 40 != 0;
         {sz, sw} = 4'(k / 40);
         {a, p, hm, en, ex, go, ge} = 41'({$urandom, $urandom});
         b = a[15:14];
         x = b == 2 ? {p, sz == 1 || sz > 1 && p < 64 - (8 << sw)}
            : {6'h3d + 6'(b - b / 3), b == 0 ? sz != 3 || hm : b == 1 ? sz < 2 || hm : 1'b0};
         e = rn ? {en & ex ? {x[0], go[6] | ~ge[6], x[6:1]} : go | ~ge, en & ex, x[0], x[6:1]}
            : 16'hff40;
         ek = rn ? (en & ex ? {x[0], go[6], x[6:1], 1'b1, ge[6], 6'h3f} : {go, ge}) : 16'h0000;
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
